// ### sdg_pkg.sv
// constants for the spi diagnostic and general pin monitor
// assumes one device master clock and a separate serial clock domain
package sdg_pkg;
    // ****************************************
    // serial frame
    // ****************************************
    localparam int          FRAME_BITS     = 24;
    localparam int          BYTE_BITS      = 8;
    localparam logic [7:0]  CRC_SEED       = 8'hA5;
    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [4:0]  CNT_W_STATUS   = 5'h00;
    localparam logic [4:0]  CNT_DATA_START = 5'h08;
    localparam logic [4:0]  CNT_CRC_START  = 5'h10;
    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_HZ         = 25000000;
    localparam int          MAP_CHECK_HZ   = 2400;
    localparam int          MAP_CHECK_CYC  = CLK_HZ / MAP_CHECK_HZ;
    localparam int          GATED_MARGIN   = 6;
    localparam int          FREE_MARGIN    = 4;
    // ****************************************
    // register addresses (7-bit space)
    // ****************************************
    localparam logic [7:0]  ADDR_SCRATCH   = 8'h0A;
    localparam logic [7:0]  ADDR_GPIO_DIR  = 8'h20;
    localparam logic [7:0]  ADDR_GPIO_DATA = 8'h21;
    localparam logic [7:0]  ADDR_ERR_SRC   = 8'h22;
    localparam logic [7:0]  ADDR_ERR_PIN   = 8'h23;
    localparam logic [7:0]  ADDR_SPI_ERR   = 8'h24;
    localparam logic [7:0]  ADDR_DIAG_ERR  = 8'h25;
    localparam logic [7:0]  ADDR_FILT_OFUF = 8'h26;
    localparam logic [7:0]  ADDR_DIAG_CTRL = 8'h27;
    localparam logic [7:0]  RST_DIAG_CTRL  = 8'h00;
    localparam logic [7:0]  RST_ZERO       = 8'h00;
endpackage

// ### sdg_monitor.sv
// spi slave with crc framing, diagnostics and eight-pin expander
// assumes sclk idles between frames; csN, sdi, pins are asynchronous
module sdg_monitor
    import sdg_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int PINS     = 8
)(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                sclk,
    input  wire logic                csN,
    input  wire logic                sdi,
    output logic                     sdo,
    input  wire logic                minIoMode,
    input  wire logic                spiControlMode,
    input  wire logic                rateSlaveMode,
    input  wire logic                pllLocked,
    input  wire logic                rateOutOfRange,
    input  wire logic                gatedMode,
    input  wire logic [15:0]         strobePeriodClk,
    input  wire logic [15:0]         frameClockTime,
    input  wire logic [CHANNELS-1:0] filterOverflow,
    output logic                     dataOutputBlock,
    input  wire logic [PINS-1:0]     pinIn,
    output logic [PINS-1:0]          pinOut,
    output logic [PINS-1:0]          pinOe
);
    // ****************************************
    // crc step
    // ****************************************
    function automatic logic [7:0] crcBit(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crcBit = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction
    function automatic logic addrKnown(input logic [6:0] a);
        addrKnown = a inside {ADDR_SCRATCH[6:0], ADDR_GPIO_DIR[6:0], ADDR_GPIO_DATA[6:0],
                              ADDR_ERR_SRC[6:0], ADDR_ERR_PIN[6:0], ADDR_SPI_ERR[6:0],
                              ADDR_DIAG_ERR[6:0], ADDR_FILT_OFUF[6:0], ADDR_DIAG_CTRL[6:0]};
    endfunction

    // ****************************************
    // serial domain
    // ****************************************
    logic [4:0]  bitCnt_r;
    logic [15:0] shIn_r;
    logic [7:0]  crc_r;
    logic [7:0]  crcRx_r;
    logic [7:0]  cmd_r;
    logic        frameErr_r;
    logic [7:0]  txSh_r;
    logic        isRead_r;
    logic [7:0]  rdData_r;
    logic [7:0]  rdDataS;
    logic        statusS;
    logic        seqTgl_r;
    logic [23:0] frame_r;
    logic [5:0]  frameLen_r;
    logic [5:0]  sclkCnt_r;

    always_ff @(posedge sclk or posedge csN)
    begin
        if (csN)
        begin
            bitCnt_r  <= 5'h00;
            sclkCnt_r <= 6'h00;
            crc_r     <= CRC_SEED;
            crcRx_r   <= CRC_SEED;
            cmd_r     <= 8'h00;
            shIn_r    <= 16'h0000;
            isRead_r  <= 1'b0;
        end
        else
        begin
            sclkCnt_r <= sclkCnt_r + 6'h01;
            if (bitCnt_r != 5'h1F)
                bitCnt_r <= bitCnt_r + 5'h01;
            shIn_r <= {shIn_r[14:0], sdi};
            if (bitCnt_r == CNT_W_STATUS)
                isRead_r <= sdi;
            if (bitCnt_r == CNT_DATA_START - 5'h01)
                cmd_r <= {shIn_r[6:0], sdi};
            // reply crc covers returned data on reads
            if (bitCnt_r < CNT_CRC_START)
            begin
                crcRx_r <= crcBit(crcRx_r, sdi);
                crc_r   <= crcBit(crc_r, (isRead_r && bitCnt_r >= CNT_DATA_START) ? sdo : sdi);
            end
        end
    end

    // transmit shifts on falling edge; status is left standing for the next frame
    always_ff @(negedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txSh_r <= 8'h00;
            sdo    <= 1'b0;
        end
        else if (!csN)
        begin
            if (bitCnt_r == CNT_DATA_START)
            begin
                sdo    <= isRead_r ? rdDataS[7] : 1'b0;
                txSh_r <= {rdDataS[6:0], 1'b0};
            end
            else if (bitCnt_r > CNT_DATA_START && bitCnt_r < CNT_CRC_START)
            begin
                sdo    <= isRead_r ? txSh_r[7] : 1'b0;
                txSh_r <= {txSh_r[6:0], 1'b0};
            end
            else if (bitCnt_r == CNT_CRC_START)
            begin
                sdo    <= crc_r[7];
                txSh_r <= {crc_r[6:0], 1'b0};
            end
            else if (bitCnt_r > CNT_CRC_START && bitCnt_r < 5'h18)
            begin
                sdo    <= txSh_r[7];
                txSh_r <= {txSh_r[6:0], 1'b0};
            end
            // leading status bit of the next frame
            else if (bitCnt_r >= 5'h18)
                sdo <= statusS;
            else
                sdo <= 1'b0;
        end
    end

    // frame capture on the 24th bit, held after deselect
    always_ff @(posedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame_r  <= 24'h000000;
            seqTgl_r <= 1'b0;
        end
        else if (!csN && bitCnt_r == 5'd23)
        begin
            frame_r  <= {cmd_r, shIn_r[14:0], sdi};
            seqTgl_r <= ~seqTgl_r;
        end
    end

    // count handed over on deselect edge (not the sclk domain)
    always_ff @(posedge csN or negedge arst_n)
    begin
        if (!arst_n)
            frameLen_r <= 6'h00;
        else
            frameLen_r <= sclkCnt_r;
    end

    // ****************************************
    // crossing into clk
    // ****************************************
    logic [2:0] csSync_r;
    logic [2:0] tglSync_r;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csSync_r  <= 3'b111;
            tglSync_r <= 3'b000;
        end
        else
        begin
            csSync_r  <= {csSync_r[1:0], csN};
            tglSync_r <= {tglSync_r[1:0], seqTgl_r};
        end
    end
    logic frameDone;
    logic csRise;
    assign frameDone = tglSync_r[2] ^ tglSync_r[1];
    assign csRise    = csSync_r[1] & ~csSync_r[2];

    // read data is quasi-static while framed; status is set on the 24th sclk rise
    logic [PINS-1:0] gpioDir_r, gpioData_r, errSrc_r, scratch_r, diagCtrl_r;
    logic [7:0]      readMux;
    assign rdDataS = rdData_r;
    assign statusS = frameErr_r;

    // ****************************************
    // frame decode
    // ****************************************
    logic        fRead;
    logic [7:0]  fData, fCrcRx;
    logic        crcOn, crcBad, addrOk, wrOk;
    assign fRead   = frame_r[23];
    logic [PINS-1:0] pinSync1_r, pinSync2_r;
    // crc forced in minimum io mode
    assign crcOn   = diagCtrl_r[0] | minIoMode;
    assign fData   = frame_r[15:8];
    assign fCrcRx  = frame_r[7:0];
    logic        errInEn_r, errOutEn_r;
    logic        clkCntErr_r, crcErr_r, rdErr_r, wrErr_r;
    logic        mapErr_r, rateErr_r, dclkErr_r;
    logic [CHANNELS-1:0] ofuf_r;
    logic [7:0]  mapRef_r;
    logic [7:0]  crcLocal_r;

    // local crc captured in sclk domain alongside frame
    always_ff @(posedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crcLocal_r <= CRC_SEED;
            frameErr_r <= 1'b0;
        end
        else if (!csN && bitCnt_r == CNT_CRC_START)
            crcLocal_r <= crcRx_r;
        // error of this frame, shown by the next
        else if (!csN && bitCnt_r == 5'h17)
            frameErr_r <= (crcOn && {shIn_r[6:0], sdi} != crcLocal_r)
                        || !addrKnown(cmd_r[6:0]);
    end

    assign crcBad = crcOn && (fCrcRx != crcLocal_r);
    always_comb
    begin
        addrOk = 1'b1;
        unique case (frame_r[23:16] & 8'h7F)
            ADDR_SCRATCH, ADDR_GPIO_DIR, ADDR_GPIO_DATA, ADDR_ERR_SRC, ADDR_ERR_PIN,
            ADDR_SPI_ERR, ADDR_DIAG_ERR, ADDR_FILT_OFUF, ADDR_DIAG_CTRL: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end
    assign wrOk = frameDone && !fRead && !crcBad && addrOk;

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gpioDir_r  <= RST_ZERO;
            gpioData_r <= RST_ZERO;
            errSrc_r   <= RST_ZERO;
            scratch_r  <= RST_ZERO;
            diagCtrl_r <= RST_DIAG_CTRL;
            errInEn_r  <= 1'b0;
            errOutEn_r <= 1'b0;
        end
        else if (wrOk)
        begin
            unique case (frame_r[23:16] & 8'h7F)
                ADDR_GPIO_DIR:  gpioDir_r  <= fData;
                ADDR_GPIO_DATA: gpioData_r <= fData;
                ADDR_ERR_SRC:   errSrc_r   <= fData;
                ADDR_SCRATCH:   scratch_r  <= fData;
                ADDR_DIAG_CTRL: diagCtrl_r <= fData;
                ADDR_ERR_PIN:
                begin
                    errOutEn_r <= fData[0];
                    errInEn_r  <= fData[1];
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // error flags, set wins over read clear
    // ****************************************
    logic rdSpiErr, rdDiagErr, rdOfuf;
    assign rdSpiErr  = frameDone && fRead && (frame_r[22:16] == ADDR_SPI_ERR[6:0]);
    assign rdDiagErr = frameDone && fRead && (frame_r[22:16] == ADDR_DIAG_ERR[6:0]);
    assign rdOfuf    = frameDone && fRead && (frame_r[22:16] == ADDR_FILT_OFUF[6:0]);
    logic clkCntBad;
    // no count check in minimum io mode
    assign clkCntBad = csRise && !minIoMode && (frameLen_r[2:0] != 3'b000);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clkCntErr_r <= 1'b0;
            crcErr_r    <= 1'b0;
            rdErr_r     <= 1'b0;
            wrErr_r     <= 1'b0;
        end
        else
        begin
            clkCntErr_r <= clkCntBad | (clkCntErr_r & ~rdSpiErr);
            crcErr_r    <= (frameDone & crcBad) | (crcErr_r & ~rdSpiErr);
            rdErr_r <= (frameDone & fRead & ~addrOk) | (rdErr_r & ~rdSpiErr);
            wrErr_r <= (frameDone & ~fRead & ~addrOk) | (wrErr_r & ~rdSpiErr);
        end
    end

    // ****************************************
    // register map check
    // ****************************************
    localparam int MCW = $clog2(MAP_CHECK_CYC + 1);
    logic [MCW-1:0] mapTick_r;
    logic [7:0]     mapNow;
    logic           mapEn;
    assign mapEn = diagCtrl_r[1];
    always_comb
    begin
        mapNow = CRC_SEED;
        for (int i = 0; i < 8; i++) mapNow = crcBit(mapNow, gpioDir_r[7 - i]);
        for (int i = 0; i < 8; i++) mapNow = crcBit(mapNow, gpioData_r[7 - i]);
        for (int i = 0; i < 8; i++) mapNow = crcBit(mapNow, errSrc_r[7 - i]);
        for (int i = 0; i < 8; i++) mapNow = crcBit(mapNow, scratch_r[7 - i]);
        for (int i = 0; i < 8; i++) mapNow = crcBit(mapNow, diagCtrl_r[7 - i]);
    end
    logic mapEnDly_r, wrDly_r;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mapTick_r  <= '0;
            mapRef_r   <= CRC_SEED;
            mapErr_r   <= 1'b0;
            mapEnDly_r <= 1'b0;
            wrDly_r    <= 1'b0;
        end
        else
        begin
            mapEnDly_r <= mapEn;
            wrDly_r    <= wrOk;
            if (mapTick_r == MCW'(MAP_CHECK_CYC - 1))
                mapTick_r <= '0;
            else
                mapTick_r <= mapTick_r + MCW'(1);
            // reference on enable and after writes
            if ((mapEn && !mapEnDly_r) || wrDly_r)
                mapRef_r <= mapNow;
            mapErr_r <= (mapEn && mapEnDly_r && !wrDly_r && mapTick_r == '0
                         && mapNow != mapRef_r) | (mapErr_r & ~rdDiagErr);
        end
    end

    // ****************************************
    // rate, data clock and filter checks
    // ****************************************
    logic [16:0] dclkNeed;
    assign dclkNeed = {1'b0, frameClockTime}
                    + 17'(gatedMode ? GATED_MARGIN : FREE_MARGIN);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rateErr_r       <= 1'b0;
            dclkErr_r       <= 1'b0;
            ofuf_r          <= '0;
            dataOutputBlock <= 1'b0;
        end
        else
        begin
            rateErr_r <= (rateSlaveMode & pllLocked & rateOutOfRange)
                       | (rateErr_r & ~rdDiagErr);
            dataOutputBlock <= rateSlaveMode & pllLocked & rateOutOfRange;
            dclkErr_r <= ({1'b0, strobePeriodClk} <= dclkNeed) | (dclkErr_r & ~rdDiagErr);
            ofuf_r <= filterOverflow | (ofuf_r & ~{CHANNELS{rdOfuf}});
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinSync1_r <= '0;
            pinSync2_r <= '0;
        end
        else
        begin
            pinSync1_r <= pinIn;
            pinSync2_r <= pinSync1_r;
        end
    end
    logic errInStat, anyErr;
    assign errInStat = errInEn_r & pinSync2_r[6];
    assign anyErr = |(errSrc_r & {1'b0, ofuf_r != '0, dclkErr_r, rateErr_r,
                                  mapErr_r, crcErr_r, rdErr_r | wrErr_r, clkCntErr_r});
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinOut <= '0;
            pinOe  <= '0;
        end
        else
        begin
            pinOe  <= spiControlMode ? gpioDir_r : '0;
            pinOut <= gpioData_r;
            if (spiControlMode && errOutEn_r)
            begin
                pinOe[7]  <= 1'b1;
                pinOut[7] <= anyErr | errInStat;
            end
            if (spiControlMode && errInEn_r)
                pinOe[6] <= 1'b0;
        end
    end

    // ****************************************
    // read data, prepared before next frame
    // ****************************************
    always_comb
    begin
        unique case (frame_r[23:16] & 8'h7F)
            ADDR_GPIO_DIR:  readMux = gpioDir_r;
            ADDR_GPIO_DATA: readMux = (pinSync2_r & ~gpioDir_r) | (gpioData_r & gpioDir_r);
            ADDR_ERR_SRC:   readMux = errSrc_r;
            ADDR_ERR_PIN:   readMux = {5'h00, errInStat, errInEn_r, errOutEn_r};
            ADDR_SCRATCH:   readMux = scratch_r;
            ADDR_DIAG_CTRL: readMux = diagCtrl_r;
            ADDR_SPI_ERR:   readMux = {4'h0, wrErr_r, rdErr_r, crcErr_r, clkCntErr_r};
            ADDR_DIAG_ERR:  readMux = {5'h00, dclkErr_r, rateErr_r, mapErr_r};
            ADDR_FILT_OFUF: readMux = 8'(ofuf_r);
            default:        readMux = 8'h00;
        endcase
    end
    // snapshot taken in the cycle the read clear lands
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_r <= 8'h00;
        else if (frameDone && fRead)
            rdData_r <= readMux;
    end
endmodule

// ### sdg_monitor_assertions.sv
// port checker for the spi diagnostic monitor
// assumes bind into sdg_monitor; sclk idles low, csN frames each transfer
module sdg_monitor_assertions
#(
    parameter int PINS = 8
)(
    input wire logic            clk,
    input wire logic            arst_n,
    input wire logic            sclk,
    input wire logic            csN,
    input wire logic            sdi,
    input wire logic            sdo,
    input wire logic            spiControlMode,
    input wire logic            rateSlaveMode,
    input wire logic            pllLocked,
    input wire logic            rateOutOfRange,
    input wire logic            dataOutputBlock,
    input wire logic [PINS-1:0] pinOe
);
    // ****************************************
    // frame bit index
    // ****************************************
    logic [4:0] bitCnt_r;
    logic       rwBit_r;
    always_ff @(posedge sclk or posedge csN)
    begin
        if (csN)
        begin
            bitCnt_r <= 5'h00;
            rwBit_r  <= 1'b0;
        end
        else
        begin
            bitCnt_r <= bitCnt_r + 5'h01;
            rwBit_r  <= (bitCnt_r == 5'h00) ? sdi : rwBit_r;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    a_pins_need_mode: assert property (@(posedge clk) disable iff (!arst_n)
        !spiControlMode [*6] |-> pinOe == '0) else $error("pins driven outside control mode");
    a_block_needs_slave: assert property (@(posedge clk) disable iff (!arst_n)
        !rateSlaveMode [*6] |-> !dataOutputBlock) else $error("output blocked outside slave mode");
    a_block_needs_lock: assert property (@(posedge clk) disable iff (!arst_n)
        !pllLocked [*6] |-> !dataOutputBlock) else $error("output blocked before lock");
    a_block_in_range: assert property (@(posedge clk) disable iff (!arst_n)
        !rateOutOfRange [*6] |-> !dataOutputBlock) else $error("output blocked while in range");
    a_block_when_bad: assert property (@(posedge clk) disable iff (!arst_n)
        (rateSlaveMode && pllLocked && rateOutOfRange) [*6] |-> dataOutputBlock)
        else $error("output not blocked while out of range");
    a_block_reset_low: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> !dataOutputBlock [*2]) else $error("output blocked after reset");
    a_reply_zero_bits: assert property (@(posedge sclk) disable iff (!arst_n)
        !csN && bitCnt_r inside {[5'h01:5'h07]} |-> !sdo) else $error("reply zero field set");
    a_write_data_zero: assert property (@(posedge sclk) disable iff (!arst_n)
        !csN && !rwBit_r && bitCnt_r inside {[5'h08:5'h0F]} |-> !sdo)
        else $error("write reply data field set");
endmodule

bind sdg_monitor sdg_monitor_assertions #(.PINS(PINS)) chk (
    .clk, .arst_n, .sclk, .csN, .sdi, .sdo, .spiControlMode, .rateSlaveMode, .pllLocked,
    .rateOutOfRange, .dataOutputBlock, .pinOe
);

// ### sdg_host_model.sv
// spi master model facing the monitor's serial port
// assumes mode 0: sclk idles low, host samples sdo just before each rise
module sdg_host_model
(
    output logic      sclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    import sdg_pkg::*;
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end
    // seed a5, msb first, no reflection
    function automatic logic [7:0] crcOf(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    // rw, address, data, crc msb first; clock only within frame
    task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx);
        rx   = 24'h000000;
        csN  = 1'b0;
        sdi  = tx[23];
        #20;
        for (int i = 0; i < nb; i++)
        begin
            #7.5;
            rx[23-i] = sdo;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            sdi  = (i < nb - 1) ? tx[22-i] : ~sdi;
        end
        #20;
        csN = 1'b1;
    endtask
endmodule

// ### sdg_monitor_bench.sv
// self-checking bench for sdg_monitor with a host spi model
// assumes sdg_pkg, the host model and the bound checker are compiled first
module sdg_monitor_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import sdg_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n, sclk, csN, sdi, sdo, minIoMode, spiControlMode, rateSlaveMode;
    logic        pllLocked, rateOutOfRange, gatedMode, dataOutputBlock;
    logic [15:0] strobePeriodClk, frameClockTime;
    logic [3:0]  filterOverflow;
    logic [7:0]  pinIn, pinOut, pinOe, d;
    logic [23:0] rx;
    int          err_total = 0;
    int          compares = 0;
    sdg_monitor dut (.clk, .arst_n, .sclk, .csN, .sdi, .sdo, .minIoMode, .spiControlMode,
        .rateSlaveMode, .pllLocked, .rateOutOfRange, .gatedMode, .strobePeriodClk,
        .frameClockTime, .filterOverflow, .dataOutputBlock, .pinIn, .pinOut, .pinOe);
    sdg_host_model host (.sclk, .csN, .sdi, .sdo);
    always #20 clk = ~clk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic frame(input logic rw, input logic [7:0] a, input logic [7:0] v,
                         input logic [7:0] bad, input int nb);
        logic [15:0] cmd;
        cmd = {rw, a[6:0], v};
        host.xfer({cmd, host.crcOf(cmd) ^ bad}, nb, rx);
        waitClk(8);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] bad);
        frame(1'b0, a, v, bad, 24);
        check({1'b0, rx[22:16]}, 8'h00);
        check(rx[15:8], 8'h00);
        check(rx[7:0], host.crcOf({1'b0, a[6:0], v}));
    endtask
    task automatic rd(input logic [7:0] a);
        frame(1'b1, a, 8'h00, 8'h00, 24);
        frame(1'b1, a, 8'h00, 8'h00, 24);
        d = rx[15:8];
        check({1'b0, rx[22:16]}, 8'h00);
        check(rx[7:0], host.crcOf({1'b1, a[6:0], d}));
    endtask
    task automatic final_report();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_crc();
        wr(ADDR_SCRATCH, 8'h3C, 8'h00);
        rd(ADDR_SCRATCH);
        check(d, 8'h3C);
        wr(ADDR_SCRATCH, 8'h5A, 8'hFF);
        rd(ADDR_SCRATCH);
        check(d, 8'h5A);
        wr(ADDR_DIAG_CTRL, 8'h01, 8'h00);
        wr(ADDR_SCRATCH, 8'hC3, 8'h01);
        frame(1'b1, ADDR_SCRATCH, 8'h00, 8'h00, 24);
        check({7'h00, rx[23]}, 8'h01);
        rd(ADDR_SCRATCH);
        check(d, 8'h5A);
        rd(ADDR_SPI_ERR);
        check(d & 8'h02, 8'h02);
        rd(ADDR_SPI_ERR);
        check(d & 8'h02, 8'h00);
        check({7'h00, rx[23]}, 8'h00);
        wr(ADDR_DIAG_CTRL, 8'h00, 8'h00);
    endtask
    task automatic t_count();
        frame(1'b1, ADDR_SCRATCH, 8'h00, 8'h00, 20);
        rd(ADDR_SPI_ERR);
        check(d & 8'h01, 8'h01);
        frame(1'b1, ADDR_SCRATCH, 8'h00, 8'h00, 16);
        rd(ADDR_SPI_ERR);
        check(d & 8'h01, 8'h00);
        minIoMode <= 1'b1;
        waitClk(4);
        frame(1'b1, ADDR_SCRATCH, 8'h00, 8'h00, 20);
        rd(ADDR_SPI_ERR);
        check(d & 8'h01, 8'h00);
        wr(ADDR_SCRATCH, 8'h99, 8'h01);
        rd(ADDR_SPI_ERR);
        check(d & 8'h02, 8'h02);
        rd(ADDR_SCRATCH);
        check(d, 8'h5A);
        minIoMode <= 1'b0;
        waitClk(4);
    endtask
    task automatic t_undef();
        wr(8'h30, 8'h11, 8'h00);
        rd(8'h31);
        rd(ADDR_SPI_ERR);
        check(d & 8'h0C, 8'h0C);
    endtask
    task automatic t_gpio();
        wr(ADDR_GPIO_DIR, 8'h0F, 8'h00);
        wr(ADDR_GPIO_DATA, 8'hA5, 8'h00);
        pinIn <= 8'h3C;
        waitClk(6);
        check(pinOe, 8'h0F);
        check(pinOut & 8'h0F, 8'h05);
        rd(ADDR_GPIO_DATA);
        check(d & 8'hF0, 8'h30);
        spiControlMode <= 1'b0;
        waitClk(8);
        check(pinOe, 8'h00);
        spiControlMode <= 1'b1;
        waitClk(4);
    endtask
    task automatic t_errpin();
        wr(ADDR_ERR_SRC, 8'h40, 8'h00);
        wr(ADDR_ERR_PIN, 8'h01, 8'h00);
        filterOverflow <= 4'h4;
        waitClk(2);
        filterOverflow <= 4'h0;
        waitClk(6);
        check({6'h00, pinOe[7], pinOut[7]}, 8'h03);
        rd(ADDR_FILT_OFUF);
        check(d, 8'h04);
        check({7'h00, pinOut[7]}, 8'h00);
        wr(ADDR_ERR_SRC, 8'h00, 8'h00);
        wr(ADDR_ERR_PIN, 8'h03, 8'h00);
        pinIn <= 8'h40;
        waitClk(6);
        check({7'h00, pinOut[7]}, 8'h01);
        rd(ADDR_ERR_PIN);
        check(d & 8'h04, 8'h04);
        pinIn <= 8'h00;
        waitClk(6);
        check({7'h00, pinOut[7]}, 8'h00);
    endtask
    task automatic t_rate();
        strobePeriodClk <= 16'h0064;
        frameClockTime <= 16'h005F;
        waitClk(8);
        rd(ADDR_DIAG_ERR);
        rd(ADDR_DIAG_ERR);
        check(d & 8'h04, 8'h00);
        gatedMode <= 1'b1;
        waitClk(8);
        rd(ADDR_DIAG_ERR);
        check(d & 8'h04, 8'h04);
        frameClockTime <= 16'h0000;
        rateSlaveMode <= 1'b1;
        rateOutOfRange <= 1'b1;
        waitClk(10);
        check({7'h00, dataOutputBlock}, 8'h00);
        pllLocked <= 1'b1;
        waitClk(10);
        check({7'h00, dataOutputBlock}, 8'h01);
        rd(ADDR_DIAG_ERR);
        check(d & 8'h02, 8'h02);
        rateOutOfRange <= 1'b0;
        waitClk(10);
        check({7'h00, dataOutputBlock}, 8'h00);
    endtask
    task automatic t_map();
        wr(ADDR_DIAG_CTRL, 8'h02, 8'h00);
        wr(ADDR_SCRATCH, 8'h77, 8'h00);
        waitClk(MAP_CHECK_CYC * 2 + 100);
        rd(ADDR_DIAG_ERR);
        check(d & 8'h01, 8'h00);
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        arst_n = 1'b0;
        {minIoMode, rateSlaveMode, pllLocked, rateOutOfRange, gatedMode} = 5'h00;
        spiControlMode = 1'b1;
        strobePeriodClk = 16'h0100;
        frameClockTime = 16'h0000;
        filterOverflow = 4'h0;
        pinIn = 8'h00;
        waitClk(20);
        check(pinOut | pinOe | {6'h00, sdo, dataOutputBlock}, 8'h00);
        arst_n <= 1'b1;
        waitClk(4);
        t_crc();
        t_count();
        t_undef();
        t_gpio();
        t_errpin();
        t_rate();
        t_map();
        final_report();
    end
    initial
    begin
        waitClk(60000);
        err_total++;
        final_report();
    end
endmodule
